/* sat_map.svh */
// address, field and code constants for the segment address translator
`ifndef SAT_MAP_SVH
`define SAT_MAP_SVH

// reference sizing
`define SAT_N_SEG 32
`define SAT_IDX_W 5
`define SAT_NODE_W 14
`define SAT_LOCAL_W 31
`define SAT_CACHE_LINES 8
`define SAT_MARK_W 8

// virtual address layout
`define SAT_IDX_HI 63
`define SAT_IDX_LO 59
`define SAT_BYPASS_BIT 58
`define SAT_REL_HI 57
`define SAT_ALIGN_BITS 6

// register bus
`define SAT_AXI_AW 12
`define SAT_OFF_STATUS 12'h000
`define SAT_OFF_FAULT_ADDR 12'h004
`define SAT_OFF_CACHE_CMD 12'h008
`define SAT_OFF_CACHE_VALID 12'h00c
`define SAT_OFF_SEG_BASE 12'h100
`define SAT_SEG_STRIDE_SH 4
`define SAT_W_BASE 2'h0
`define SAT_W_NODE 2'h1
`define SAT_W_CFG 2'h2
`define SAT_RESP_OKAY 2'h0
`define SAT_RESP_SLVERR 2'h2

// segment configuration word fields
`define SAT_CFG_EXP_LSB 0
`define SAT_CFG_LOW_LSB 8
`define SAT_CFG_HIGH_LSB 16
`define SAT_CFG_CACHE_BIT 24

// cache command word fields and opcodes
`define SAT_CMD_OP_LSB 0
`define SAT_CMD_LINE_LSB 8
`define SAT_CMD_MARK_LSB 16
`define SAT_OP_INV_LINE 2'h1
`define SAT_OP_SET_MARK 2'h2
`define SAT_OP_GANG_INV 2'h3

`endif

/* sat_pkg.sv */
// types and helpers shared by the segment address translator
`default_nettype none
`include "sat_map.svh"
package sat_pkg;
    typedef struct packed {
        logic cacheable;
        logic [5:0] stripe_high_position;
        logic [5:0] stripe_low_position;
        logic [5:0] segment_size_exponent;
        logic [`SAT_NODE_W-1:0] first_node_of_segment;
        logic [31:0] segment_base_in_node;
    } sat_seg_entry_t;

    typedef struct packed {
        logic [63:0] vaddr;
        logic priv;
        logic cache_ok;
        logic store;
    } sat_req_t;

    typedef struct packed {
        logic issue;
        logic fault;
        logic bypassed;
        logic cache_use;
        logic cache_hit;
        logic [`SAT_NODE_W-1:0] node;
        logic [63:0] absolute_node_address;
    } sat_rsp_t;

    typedef struct packed {
        logic ok;
        logic is_entry;
        logic [`SAT_IDX_W-1:0] idx;
        logic [1:0] word;
    } sat_dec_t;

    // ones in the lowest n bits
    function automatic logic [63:0] sat_lowmask(input logic [6:0] n);
        sat_lowmask = (n >= 7'h40) ? 64'hffffffffffffffff : ((64'h1 << n) - 64'h1);
    endfunction
endpackage
`default_nettype wire

/* sat_stripe_split.sv */
// splits a segment-relative address into node offset and in-node offset
`timescale 1ns/1ps
`default_nettype none
`include "sat_map.svh"
module sat_stripe_split
    import sat_pkg::*;
(
    // address and stripe positions
    input wire logic [63:0] i_rel,
    input wire logic [5:0] i_low,
    input wire logic [5:0] i_high,
    // split results
    output logic [63:0] o_node_off,
    output logic [63:0] o_offset,
    output logic o_bad
);
    logic [6:0] width;
    logic [63:0] upper_offset_part;
    logic [63:0] lower_offset_part;

    assign o_bad = i_high < i_low;
    assign width = 7'({1'b0, i_high}) - 7'({1'b0, i_low}) + 7'h1;
    assign o_node_off = (i_rel >> i_low) & sat_lowmask(width); // RQ4 RQ9
    assign lower_offset_part = i_rel & sat_lowmask({1'b0, i_low}); // RQ4
    assign upper_offset_part = i_rel >> (7'({1'b0, i_high}) + 7'h1); // RQ4
    assign o_offset = (upper_offset_part << i_low) | lower_offset_part; // RQ4
endmodule
`default_nettype wire

/* sat_stream_cache.sv */
// read-only stream cache tag store with line and gang invalidation
`timescale 1ns/1ps
`default_nettype none
`include "sat_map.svh"
module sat_stream_cache
    import sat_pkg::*;
#(
    parameter int LINES = `SAT_CACHE_LINES,
    parameter int MARK_W = `SAT_MARK_W
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // lookup and fill
    input wire logic i_lookup,
    input wire logic i_fill,
    input wire logic [63:0] i_addr,
    // maintenance command
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_op,
    input wire logic [7:0] i_cmd_line,
    input wire logic [MARK_W-1:0] i_cmd_mark,
    // results
    output logic o_hit,
    output logic [LINES-1:0] o_valid_bits
);
    localparam int IW = $clog2(LINES);
    localparam int TW = 64 - `SAT_ALIGN_BITS - IW;

    logic [LINES-1:0] valid_r;
    logic [TW-1:0] tag_r [LINES];
    logic [MARK_W-1:0] mark_r [LINES];
    logic [IW-1:0] line;
    logic [IW-1:0] cmd_line;
    logic [TW-1:0] tag;
    logic do_fill;

    assign line = i_addr[`SAT_ALIGN_BITS+IW-1:`SAT_ALIGN_BITS];
    assign tag = i_addr[63:`SAT_ALIGN_BITS+IW];
    assign cmd_line = i_cmd_line[IW-1:0];
    assign o_hit = i_lookup && valid_r[line] && (tag_r[line] == tag);
    assign o_valid_bits = valid_r;
    // stores never fill: the cache only holds read data
    assign do_fill = i_lookup && i_fill && !o_hit; // RQ11

    // valid bits fall only on explicit invalidation
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            valid_r <= '0;
        end else if (i_cmd_valid) begin
            case (i_cmd_op)
                `SAT_OP_INV_LINE: valid_r[cmd_line] <= 1'b0; // RQ16
                `SAT_OP_GANG_INV: begin
                    for (int i = 0; i < LINES; i++) begin
                        if ((mark_r[i] & i_cmd_mark) != '0) begin
                            valid_r[i] <= 1'b0; // RQ16
                        end
                    end
                end
                default: ;
            endcase
        end else if (do_fill) begin
            valid_r[line] <= 1'b1; // RQ11
        end
    end

    // tags and marker bits
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < LINES; i++) begin
                tag_r[i] <= '0;
                mark_r[i] <= '0;
            end
        end else if (i_cmd_valid) begin
            if (i_cmd_op == `SAT_OP_SET_MARK) begin
                mark_r[cmd_line] <= i_cmd_mark; // RQ16
            end
        end else if (do_fill) begin
            tag_r[line] <= tag;
            mark_r[line] <= '0;
        end
    end

    chk_readonly_keep: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ11
        !$past(i_cmd_valid) |-> (($past(valid_r) & ~valid_r) == '0))
        else $error("cache line dropped without an invalidate command");
endmodule
`default_nettype wire

/* sat_top.sv */
// segment address translator: axi4-lite segment file and translation path
// Operation
// RQ1: the segment index field of the address picks one of 32 entries
// RQ2: node-relative 64-bit virtual addresses become system-wide 64-bit physical addresses
// RQ3: the low six address bits are ignored and forced to zero
// RQ4: stripe positions split the relative address into upper, lower and node parts
// RQ5: target node is first node of segment plus node offset part
// RQ6: in-node address is segment base plus the joined offset parts
// RQ7: in-node offset must stay below two to the size exponent
// RQ8: software gives size exponent above six and a word-aligned base
// RQ9: a segment spans two to the stripe width nodes
// RQ10: caching needs a cacheable segment and a request that permits it
// RQ11: stream cache is read-only; lines leave only by explicit invalidation (a read miss fill also replaces the resident line here)
// RQ12: privileged bypass uses the relative field as a local physical address
// RQ13: bypass bit honoured only for privileged requests
// RQ14: segment entries are read and written only by privileged accesses
// RQ15: each stream request states whether the stream cache may be used
// RQ16: cache supports single line invalidate and marker bits for gang invalidate
// RQ17: fields sized for 16384 nodes of two gigabytes each
// RQ18: bound violations are flagged and the memory access suppressed
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sat_map.svh"
module sat_top
    import sat_pkg::*;
#(
    parameter int N_SEG = `SAT_N_SEG,
    parameter int CACHE_LINES = `SAT_CACHE_LINES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // node identity
    input wire logic [`SAT_NODE_W-1:0] i_node_id,
    // translation request
    input wire logic i_req_valid,
    input wire sat_req_t i_req,
    // translation response
    output logic o_rsp_valid,
    output var sat_rsp_t o_rsp,
    // axi4-lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [`SAT_AXI_AW-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [`SAT_AXI_AW-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);
    sat_seg_entry_t seg_r [N_SEG];
    logic awready_r, wready_r, aw_full_r, w_full_r, bvalid_r;
    logic arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r, wdata_r;
    logic [3:0] wstrb_r;
    logic [2:0] awprot_r;
    logic [`SAT_AXI_AW-1:0] awaddr_r;
    logic fault_r;
    logic [31:0] fault_vaddr_r;
    logic rsp_valid_r;
    sat_rsp_t rsp_r;

    function automatic sat_dec_t decode(input logic [`SAT_AXI_AW-1:0] a);
        logic [`SAT_AXI_AW-1:0] rel;
        decode = '0;
        rel = a - `SAT_OFF_SEG_BASE;
        decode.idx = rel[`SAT_SEG_STRIDE_SH+`SAT_IDX_W-1:`SAT_SEG_STRIDE_SH];
        decode.word = a[3:2];
        if (a >= `SAT_OFF_SEG_BASE) begin
            decode.is_entry = (32'(rel >> `SAT_SEG_STRIDE_SH) < N_SEG) && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
            decode.ok = decode.is_entry;
        end else begin
            decode.ok = (a == `SAT_OFF_STATUS) || (a == `SAT_OFF_FAULT_ADDR) ||
                (a == `SAT_OFF_CACHE_CMD) || (a == `SAT_OFF_CACHE_VALID);
        end
    endfunction

    function automatic logic [31:0] cfg_word(input sat_seg_entry_t e);
        cfg_word = '0;
        cfg_word[`SAT_CFG_EXP_LSB+:6] = e.segment_size_exponent;
        cfg_word[`SAT_CFG_LOW_LSB+:6] = e.stripe_low_position;
        cfg_word[`SAT_CFG_HIGH_LSB+:6] = e.stripe_high_position;
        cfg_word[`SAT_CFG_CACHE_BIT] = e.cacheable;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[b*8+:8] = s[b] ? nw[b*8+:8] : old[b*8+:8];
        end
    endfunction

    // write channel
    logic wr_go, wr_ok;
    sat_dec_t wr_dec;
    logic [31:0] wr_word;
    assign wr_go = aw_full_r && w_full_r && !bvalid_r;
    assign wr_dec = decode(awaddr_r);
    assign wr_ok = wr_dec.ok && awprot_r[0]; // RQ14

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `SAT_RESP_OKAY;
            awaddr_r <= '0;
            awprot_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (i_awvalid && awready_r) begin
                awaddr_r <= i_awaddr;
                awprot_r <= i_awprot;
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (i_wvalid && wready_r) begin
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? `SAT_RESP_OKAY : `SAT_RESP_SLVERR; // RQ14
            end else if (bvalid_r && i_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // segment entry programming
    assign wr_word = wr_dec.word == `SAT_W_BASE ? seg_r[wr_dec.idx].segment_base_in_node :
        wr_dec.word == `SAT_W_NODE ? 32'(seg_r[wr_dec.idx].first_node_of_segment) : cfg_word(seg_r[wr_dec.idx]);
    logic [31:0] wr_merged;
    assign wr_merged = merge(wr_word, wdata_r, wstrb_r);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < N_SEG; i++) begin
                seg_r[i] <= '0;
            end
        end else if (wr_go && wr_ok && wr_dec.is_entry) begin // RQ14
            case (wr_dec.word)
                `SAT_W_BASE: seg_r[wr_dec.idx].segment_base_in_node <= wr_merged;
                `SAT_W_NODE: begin
                    seg_r[wr_dec.idx].first_node_of_segment <= wr_merged[`SAT_NODE_W-1:0];
                end
                `SAT_W_CFG: begin
                    seg_r[wr_dec.idx].segment_size_exponent <= wr_merged[`SAT_CFG_EXP_LSB+:6];
                    seg_r[wr_dec.idx].stripe_low_position <= wr_merged[`SAT_CFG_LOW_LSB+:6];
                    seg_r[wr_dec.idx].stripe_high_position <= wr_merged[`SAT_CFG_HIGH_LSB+:6];
                    seg_r[wr_dec.idx].cacheable <= wr_merged[`SAT_CFG_CACHE_BIT];
                end
                default: ;
            endcase
        end
    end

    // translation path
    logic [`SAT_IDX_W-1:0] idx;
    logic idx_ok, bypass_on, split_bad, node_ovf, local_ovf, range_bad, t_fault, cache_use, cache_hit;
    sat_seg_entry_t ent;
    logic [63:0] segment_relative_address, node_offset_part, offset_within_segment, abs_addr;
    logic [`SAT_NODE_W:0] node_sum;
    logic [64:0] local_sum;
    logic [`SAT_NODE_W-1:0] t_node;
    logic [CACHE_LINES-1:0] cache_valid;

    assign idx = i_req.vaddr[`SAT_IDX_HI:`SAT_IDX_LO]; // RQ1
    assign idx_ok = 32'(idx) < N_SEG; // RQ1
    assign ent = idx_ok ? seg_r[idx] : '0; // RQ1
    assign segment_relative_address = {6'h0, i_req.vaddr[`SAT_REL_HI:`SAT_ALIGN_BITS], 6'h0}; // RQ2 RQ3
    assign bypass_on = i_req.vaddr[`SAT_BYPASS_BIT] && i_req.priv; // RQ12 RQ13

    sat_stripe_split u_split (
        .i_rel(segment_relative_address),
        .i_low(ent.stripe_low_position),
        .i_high(ent.stripe_high_position),
        .o_node_off(node_offset_part),
        .o_offset(offset_within_segment),
        .o_bad(split_bad)
    );

    assign node_sum = {1'b0, ent.first_node_of_segment} + {1'b0, node_offset_part[`SAT_NODE_W-1:0]}; // RQ5
    assign node_ovf = node_sum[`SAT_NODE_W] || (node_offset_part[63:`SAT_NODE_W] != '0); // RQ17
    assign local_sum = bypass_on ? {1'b0, segment_relative_address} :
        65'(ent.segment_base_in_node) + {1'b0, offset_within_segment}; // RQ6 RQ12
    assign local_ovf = local_sum[64:`SAT_LOCAL_W] != '0; // RQ17
    assign range_bad = (offset_within_segment >> ent.segment_size_exponent) != '0; // RQ7
    assign t_fault = bypass_on ? local_ovf : (!idx_ok || split_bad || node_ovf || local_ovf || range_bad); // RQ18
    assign t_node = bypass_on ? i_node_id : node_sum[`SAT_NODE_W-1:0]; // RQ12
    assign abs_addr = {{(64 - `SAT_NODE_W - `SAT_LOCAL_W){1'b0}}, t_node,
        local_sum[`SAT_LOCAL_W-1:`SAT_ALIGN_BITS], 6'h0}; // RQ2 RQ3
    assign cache_use = !t_fault && !bypass_on && ent.cacheable && i_req.cache_ok; // RQ10 RQ15

    sat_stream_cache #(
        .LINES(CACHE_LINES),
        .MARK_W(`SAT_MARK_W)
    ) u_cache (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_lookup(i_req_valid && cache_use),
        .i_fill(!i_req.store),
        .i_addr(abs_addr),
        .i_cmd_valid(wr_go && wr_ok && (awaddr_r == `SAT_OFF_CACHE_CMD)), // RQ16
        .i_cmd_op(wdata_r[`SAT_CMD_OP_LSB+:2]),
        .i_cmd_line(wdata_r[`SAT_CMD_LINE_LSB+:8]),
        .i_cmd_mark(wdata_r[`SAT_CMD_MARK_LSB+:`SAT_MARK_W]),
        .o_hit(cache_hit),
        .o_valid_bits(cache_valid)
    );

    // response register
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            rsp_valid_r <= i_req_valid;
            if (i_req_valid) begin
                rsp_r.issue <= !t_fault; // RQ18
                rsp_r.fault <= t_fault; // RQ18
                rsp_r.bypassed <= bypass_on; // RQ13
                rsp_r.cache_use <= cache_use; // RQ10
                rsp_r.cache_hit <= cache_hit;
                rsp_r.node <= t_fault ? '0 : t_node; // RQ5
                rsp_r.absolute_node_address <= t_fault ? '0 : abs_addr; // RQ18
            end
        end
    end

    // fault status, set wins over clear
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            fault_r <= 1'b0;
            fault_vaddr_r <= '0;
        end else begin
            fault_r <= (i_req_valid && t_fault) ||
                (fault_r && !(wr_go && wr_ok && awaddr_r == `SAT_OFF_STATUS && wstrb_r[0] && wdata_r[0])); // RQ18
            if (i_req_valid && t_fault) begin
                fault_vaddr_r <= i_req.vaddr[31:0];
            end
        end
    end

    // read channel
    sat_dec_t rd_dec;
    logic [31:0] rd_word;
    assign rd_dec = decode(i_araddr);
    always_comb begin
        rd_word = '0;
        if (rd_dec.is_entry) begin
            case (rd_dec.word)
                `SAT_W_BASE: rd_word = seg_r[rd_dec.idx].segment_base_in_node;
                `SAT_W_NODE: rd_word = 32'(seg_r[rd_dec.idx].first_node_of_segment);
                default: rd_word = cfg_word(seg_r[rd_dec.idx]);
            endcase
        end else if (i_araddr == `SAT_OFF_STATUS) begin
            rd_word = 32'(fault_r);
        end else if (i_araddr == `SAT_OFF_FAULT_ADDR) begin
            rd_word = fault_vaddr_r;
        end else if (i_araddr == `SAT_OFF_CACHE_VALID) begin
            rd_word = 32'(cache_valid);
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `SAT_RESP_OKAY;
        end else if (i_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= (rd_dec.ok && i_arprot[0]) ? rd_word : '0; // RQ14
            rresp_r <= (rd_dec.ok && i_arprot[0]) ? `SAT_RESP_OKAY : `SAT_RESP_SLVERR; // RQ14
        end else if (rvalid_r && i_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign o_awready = awready_r;
    assign o_wready = wready_r;
    assign o_bvalid = bvalid_r;
    assign o_bresp = bresp_r;
    assign o_arready = arready_r;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_rresp = rresp_r;
    assign o_rsp_valid = rsp_valid_r;
    assign o_rsp = rsp_r;

    chk_rsp_follows_req: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ2
        i_req_valid |=> o_rsp_valid) else $error("no response one cycle after request");
    chk_paddr_aligned: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ3
        o_rsp_valid |-> o_rsp.absolute_node_address[5:0] == 6'h0) else $error("physical address not word aligned");
    chk_index_range: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ1
        i_req_valid && !bypass_on && !idx_ok |=> o_rsp.fault) else $error("unmapped segment index not faulted");
    chk_node_sum: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ5
        i_req_valid && !bypass_on && !t_fault |=>
        o_rsp.node == `SAT_NODE_W'($past(ent.first_node_of_segment) + $past(node_offset_part[`SAT_NODE_W-1:0])))
        else $error("target node is not first node plus node offset");
    chk_local_sum: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ6
        i_req_valid && !bypass_on && !t_fault |=> o_rsp.absolute_node_address[`SAT_LOCAL_W-1:6] ==
        $past(ent.segment_base_in_node[`SAT_LOCAL_W-1:6]) + $past(offset_within_segment[`SAT_LOCAL_W-1:6]))
        else $error("in-node address is not base plus offset");
    chk_bound_fault: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ7
        i_req_valid && !bypass_on && range_bad |=> o_rsp.fault && !o_rsp.issue && fault_r)
        else $error("out-of-segment access not flagged");
    chk_fault_suppress: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ18
        o_rsp_valid && o_rsp.fault |-> !o_rsp.issue && o_rsp.absolute_node_address == '0 && fault_r)
        else $error("faulting access still issued");
    chk_cache_policy: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ10
        o_rsp_valid && o_rsp.cache_use |-> $past(i_req.cache_ok) && $past(ent.cacheable))
        else $error("cache used against segment or request policy");
    chk_bypass_node: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ12
        i_req_valid && bypass_on && !t_fault |=> o_rsp.bypassed && o_rsp.node == $past(i_node_id))
        else $error("bypass did not target the current node");
    chk_bypass_priv: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ13
        o_rsp_valid && o_rsp.bypassed |-> $past(i_req.priv)) else $error("bypass honoured without privilege");
    chk_unpriv_write: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ14
        wr_go && !awprot_r[0] |=> bvalid_r && bresp_r == `SAT_RESP_SLVERR)
        else $error("unprivileged register write accepted");
endmodule
`default_nettype wire

/* sat_proc_model.sv */
// scalar processor model issuing translation requests
`timescale 1ns/1ps
`default_nettype none
module sat_proc_model
    import sat_pkg::*;
(
    // clock
    input wire logic i_clock,
    // request side
    output logic o_req_valid,
    output var sat_req_t o_req
);
    initial begin
        o_req_valid = 1'b0;
        o_req = '0;
    end
    // one request per call, payload scrambled once released
    task automatic issue(input logic [63:0] va, input logic pv, input logic ok, input logic st);
        @(posedge i_clock);
        o_req_valid <= 1'b1;
        o_req <= '{va, pv, ok, st};
        @(posedge i_clock);
        o_req_valid <= 1'b0;
        o_req <= ~o_req;
    endtask
endmodule
`default_nettype wire

/* sat_top_tb.sv */
// self-checking bench for the segment address translator
`timescale 1ns/1ps
`default_nettype none
module sat_top_tb
    import sat_pkg::*;
;
    localparam logic T = 1'b1;
    localparam logic F = 1'b0;
    localparam logic [63:0] V1 = 64'h0800000000000000;
    localparam logic [63:0] BY = 64'h0400000000000000;
    localparam logic [63:0] PA = 64'h0000001100001ec0;
    logic clock, nrst = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic [11:0] aw_a = 0, ar_a = 0;
    logic [2:0] aw_p = 0, ar_p = 0;
    logic [31:0] w_d = 0, r_d;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, rsp_v, req_v;
    logic [1:0] b_rs, r_rs;
    sat_rsp_t rsp;
    sat_req_t req;
    int bad_count = 0;
    int n_checks = 0;
    sat_proc_model PM (.i_clock(clock), .o_req_valid(req_v), .o_req(req));
    sat_top DUT (.i_clock(clock), .i_nrst(nrst), .i_node_id(14'h0155), .i_req_valid(req_v), .i_req(req),
        .o_rsp_valid(rsp_v), .o_rsp(rsp), .i_awvalid(aw_v), .o_awready(aw_rdy), .i_awaddr(aw_a),
        .i_awprot(aw_p), .i_wvalid(w_v), .o_wready(w_rdy), .i_wdata(w_d), .i_wstrb(4'hf), .o_bvalid(b_v),
        .i_bready(b_r), .o_bresp(b_rs), .i_arvalid(ar_v), .o_arready(ar_rdy), .i_araddr(ar_a),
        .i_arprot(ar_p), .o_rvalid(r_v), .i_rready(r_r), .o_rdata(r_d), .o_rresp(r_rs));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [95:0] g, input logic [95:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick(inout int n);
        @(posedge clock);
        n++;
        if (n > 20) begin
            bad_count++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic p, input logic [1:0] er);
        int n = 0;
        @(posedge clock);
        {aw_a, w_d, aw_p, aw_v, w_v, b_r} <= {a, d, 2'h0, p, 3'h7};
        do begin
            tick(n);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (!b_v);
        b_r <= 1'b0;
        cmp({94'h0, b_rs}, {94'h0, er});
    endtask
    task automatic rd(input logic [11:0] a, input logic p, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge clock);
        {ar_a, ar_p, ar_v, r_r} <= {a, 2'h0, p, 2'h3};
        do begin
            tick(n);
            if (ar_rdy) ar_v <= 1'b0;
        end while (!r_v);
        r_r <= 1'b0;
        cmp({62'h0, r_rs, r_d}, {62'h0, er, ed});
    endtask
    task automatic xl(input logic [63:0] va, input logic pv, input logic ok, input logic st, input sat_rsp_t e);
        PM.issue(va, pv, ok, st);
        @(posedge clock);
        cmp({12'h0, rsp_v, rsp}, {12'h0, T, e});
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        rd(12'h000, T, 32'h0, 2'h0);
        wr(12'h110, 32'h00001000, T, 2'h0);
        wr(12'h114, 32'h00000020, T, 2'h0);
        wr(12'h118, 32'h0009080c, T, 2'h0);
        wr(12'h110, 32'h0, F, 2'h2);
        rd(12'h110, F, 32'h0, 2'h2);
        rd(12'h110, T, 32'h00001000, 2'h0);
        rd(12'h11c, T, 32'h0, 2'h2);
        $display("test registers done");
        xl(V1 | 64'h3ac0, T, T, F, '{T, F, F, F, F, 14'h0022, PA});
        wr(12'h118, 32'h0109080c, T, 2'h0);
        xl(V1 | 64'h3aff, T, T, F, '{T, F, F, T, F, 14'h0022, PA});
        xl(V1 | 64'h3ac0, F, T, F, '{T, F, F, T, T, 14'h0022, PA});
        xl(V1 | 64'h10000, T, F, F, '{F, T, F, F, F, 14'h0, 64'h0});
        rd(12'h004, T, 32'h00010000, 2'h0);
        rd(12'h000, T, 32'h1, 2'h0);
        wr(12'h000, 32'h1, T, 2'h0);
        rd(12'h000, T, 32'h0, 2'h0);
        xl(BY | 64'h1240, T, F, F, '{T, F, T, F, F, 14'h0155, 64'h000000aa80001240});
        xl(BY | 64'h1240, F, F, F, '{F, T, F, F, F, 14'h0, 64'h0});
        $display("test translation done");
        for (int i = 0; i < 8; i++) wr(12'h008, {16'h0, i[7:0], 8'h01}, T, 2'h0);
        rd(12'h00c, T, 32'h0, 2'h0);
        xl(V1 | 64'h3ac0, T, T, T, '{T, F, F, T, F, 14'h0022, PA});
        xl(V1 | 64'h3ac0, T, T, F, '{T, F, F, T, F, 14'h0022, PA});
        $display("test cache done");
        give_verdict();
    end
endmodule
`default_nettype wire
